// File: logic/lpsc_stop_ctrl.sv
// Notes on behaviour
// - Stop opcode enters full stop if oscillator irq enable 0, time-base sleep if 1.
// - Time-base sleep exits only on time-base irq or reset; irq skips wait.
// - Stabilisation wait after time-base sleep applies only to reset exit.
// - Entering either sleep forces interrupt priority bits to 10b.
// - In time-base sleep only oscillator and time-base counter stay clocked.
// - Time-base sleep with watchdog active does not cause a reset.
// - Full stop exits on reset or wake irq after 256/4096-cycle wait.
// - In full stop the main oscillator is off and peripherals stop.
// - Stop with watchdog enabled may give watchdog reset per option bit.
// - Interrupt entry pushes condition code priority and loads routine priority; pop restores.
// - Opcode 0x8E is decoded as the stop instruction.
`timescale 1ns/100ps
module lpsc_stop_ctrl
  import lpsc_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // CPU core
  input  wire logic        instr_valid_in,
  input  wire logic [7:0]  opcode_in,
  input  wire logic        irq_take_in,
  input  wire logic [1:0]  irq_level_in,
  input  wire logic        cc_pop_in,
  input  wire logic [1:0]  cc_pop_value_in,
  output logic [1:0]       cc_priority_out,
  output logic             cc_push_out,
  output logic [1:0]       cc_push_value_out,
  output logic             cpu_stall_out,
  // Wake sources and watchdog
  input  wire logic        time_base_irq_in,
  input  wire logic        wake_irq_in,
  input  wire logic        watchdog_active_in,
  output logic             watchdog_reset_req_out,
  // Clock gating
  output logic             osc_enable_out,
  output logic             time_base_clk_en_out,
  output logic             periph_clk_en_out
);
  // ==========================================================
  // Declarations
  lpsc_state_e  state_q;
  lpsc_state_e  state_d;
  logic [2:0]   ctrl_q;
  logic [1:0]   cc_prio_q;
  logic         osc_irq_enable;
  logic         delay_long;
  logic         watchdog_in_stop_option;
  logic         stop_cmd;
  logic         wd_reset_cond;
  logic         cnt_load;
  logic [12:0]  cnt_value;
  logic         cnt_busy;
  logic         cnt_expire;
  logic         enter_sleep;
  logic         apb_setup;
  logic         apb_write;
  logic         addr_ok;

  assign osc_irq_enable          = ctrl_q[CTRL_OSC_IRQ_BIT];
  assign delay_long              = ctrl_q[CTRL_LONG_DLY_BIT];
  assign watchdog_in_stop_option = ctrl_q[CTRL_WD_STOP_BIT];

  // ==========================================================
  // APB slave
  assign apb_setup   = psel_in && !penable_in;
  assign apb_write   = psel_in && penable_in && pwrite_in;
  assign addr_ok     = (paddr_in == CTRL_OFFSET) || (paddr_in == STATUS_OFFSET);
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !addr_ok;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_q <= CTRL_RESET;
    end else if (apb_write && (paddr_in == CTRL_OFFSET)) begin
      ctrl_q <= pwdata_in[2:0];
    end
  end

  // Read data captured in the setup cycle, valid during access
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (apb_setup && !pwrite_in) begin
      if (paddr_in == CTRL_OFFSET) begin
        prdata_out <= {29'h0000_0000, ctrl_q};
      end else if (paddr_in == STATUS_OFFSET) begin
        prdata_out <= {24'h00_0000, cc_prio_q, cpu_stall_out, state_q};
      end else begin
        prdata_out <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Instruction decode and watchdog
  assign stop_cmd      = instr_valid_in && (opcode_in == OPCODE_STOP)
                         && (state_q == ST_RUN);
  assign wd_reset_cond = !osc_irq_enable && watchdog_active_in
                         && watchdog_in_stop_option;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      watchdog_reset_req_out <= 1'b0;
    end else begin
      watchdog_reset_req_out <= stop_cmd && wd_reset_cond;
    end
  end

  // ==========================================================
  // Power state machine
  always_comb begin
    state_d   = state_q;
    cnt_load  = 1'b0;
    cnt_value = delay_long ? STAB_LONG_CYCLES : STAB_SHORT_CYCLES;
    unique case (state_q)
      ST_RUN: begin
        if (stop_cmd && osc_irq_enable) begin
          state_d = ST_TB_SLEEP;
        end else if (stop_cmd && !wd_reset_cond) begin
          state_d = ST_STOP;
        end else if (cnt_busy && !osc_irq_enable) begin
          state_d = ST_GUARD;
        end
      end
      ST_TB_SLEEP: begin
        if (time_base_irq_in) begin
          state_d  = ST_RUN;
          cnt_load = 1'b1;
        end
      end
      ST_STOP: begin
        if (wake_irq_in) begin
          state_d  = ST_STAB;
          cnt_load = 1'b1;
        end
      end
      ST_STAB: begin
        if (cnt_expire) begin
          state_d = ST_RUN;
        end
      end
      ST_GUARD: begin
        if (cnt_expire || !cnt_busy) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_STAB;
      end
    endcase
  end

  // Reset leaves through the stabilisation wait
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= ST_STAB;
    end else begin
      state_q <= state_d;
    end
  end

  lpsc_stab_counter #(
    .W (CNT_W)
  ) u_stab (
    .clock_in      (clock_in),
    .reset_in      (reset_in),
    .load_in       (cnt_load),
    .load_value_in (cnt_value),
    .busy_out      (cnt_busy),
    .expire_out    (cnt_expire)
  );

  // ==========================================================
  // Clock gating and stall
  assign cpu_stall_out        = (state_q != ST_RUN);
  assign osc_enable_out       = (state_q != ST_STOP) && (state_q != ST_GUARD);
  assign time_base_clk_en_out = (state_q == ST_RUN) || (state_q == ST_TB_SLEEP);
  assign periph_clk_en_out    = (state_q == ST_RUN);

  // ==========================================================
  // Condition code priority bits
  assign enter_sleep     = (state_q == ST_RUN)
                           && ((state_d == ST_TB_SLEEP) || (state_d == ST_STOP));
  assign cc_priority_out = cc_prio_q;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      cc_prio_q <= PRIO_RESET;
    end else if (enter_sleep) begin
      cc_prio_q <= PRIO_SLEEP;
    end else if (irq_take_in) begin
      cc_prio_q <= irq_level_in;
    end else if (cc_pop_in) begin
      cc_prio_q <= cc_pop_value_in;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      cc_push_out       <= 1'b0;
      cc_push_value_out <= PRIO_RESET;
    end else begin
      cc_push_out <= irq_take_in && !enter_sleep;
      if (irq_take_in && !enter_sleep) begin
        cc_push_value_out <= cc_prio_q;
      end
    end
  end

  // ==========================================================
  // Assertions
  a_stop_tb_sleep: assert property (@(posedge clock_in) disable iff (reset_in)
    stop_cmd && osc_irq_enable |=> state_q == ST_TB_SLEEP)
    else $error("stop with irq enable set did not enter time-base sleep");

  a_stop_full: assert property (@(posedge clock_in) disable iff (reset_in)
    stop_cmd && !osc_irq_enable && !wd_reset_cond |=> state_q == ST_STOP && !osc_enable_out)
    else $error("stop with irq enable clear did not enter full stop");

  a_tb_wake_direct: assert property (@(posedge clock_in) disable iff (reset_in)
    state_q == ST_TB_SLEEP && time_base_irq_in |=> !cpu_stall_out)
    else $error("time-base wake did not release the cpu at once");

  a_tb_stays_asleep: assert property (@(posedge clock_in) disable iff (reset_in)
    state_q == ST_TB_SLEEP && !time_base_irq_in |=> state_q == ST_TB_SLEEP)
    else $error("time-base sleep left without time-base irq");

  a_prio_forced: assert property (@(posedge clock_in) disable iff (reset_in)
    enter_sleep |=> cc_priority_out == PRIO_SLEEP)
    else $error("priority bits not forced on sleep entry");

  a_tb_clocks: assert property (@(posedge clock_in) disable iff (reset_in)
    state_q == ST_TB_SLEEP |-> osc_enable_out && time_base_clk_en_out && !periph_clk_en_out)
    else $error("wrong clocks in time-base sleep");

  a_no_wd_tb: assert property (@(posedge clock_in) disable iff (reset_in)
    stop_cmd && osc_irq_enable && watchdog_active_in && watchdog_in_stop_option
      |=> !watchdog_reset_req_out && state_q == ST_TB_SLEEP)
    else $error("watchdog reset on time-base sleep entry");

  a_guard_stop: assert property (@(posedge clock_in) disable iff (reset_in)
    state_q == ST_RUN && cnt_busy && !osc_irq_enable && !stop_cmd |=> state_q == ST_GUARD)
    else $error("early irq enable clear did not fall into stop");

  a_stab_short: assert property (@(posedge clock_in) disable iff (reset_in)
    state_q == ST_STOP && wake_irq_in && !delay_long |=> cpu_stall_out [*8] ##248 cpu_stall_out ##1 !cpu_stall_out)
    else $error("short stabilisation wait not 256 cycles");

  a_stop_osc_off: assert property (@(posedge clock_in) disable iff (reset_in)
    state_q == ST_STOP |-> !osc_enable_out && !periph_clk_en_out && !time_base_clk_en_out)
    else $error("oscillator running in full stop");

  a_wd_reset: assert property (@(posedge clock_in) disable iff (reset_in)
    stop_cmd && wd_reset_cond |=> watchdog_reset_req_out && state_q == ST_RUN)
    else $error("watchdog reset not requested on stop");

  a_push_prio: assert property (@(posedge clock_in) disable iff (reset_in)
    irq_take_in && !enter_sleep |=> cc_push_out && cc_priority_out == $past(irq_level_in)
      && cc_push_value_out == $past(cc_prio_q))
    else $error("priority not pushed and loaded on irq entry");

  a_stab_stall: assert property (@(posedge clock_in) disable iff (reset_in)
    state_q == ST_STAB && !cnt_expire |=> state_q == ST_STAB && cpu_stall_out)
    else $error("stabilisation wait ended before counter expiry");

  // Cycles spent in the stabilisation wait, for the length check
  logic [12:0] stab_cycles_q;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      stab_cycles_q <= 13'h0000;
    end else if (state_q == ST_STAB) begin
      stab_cycles_q <= stab_cycles_q + 13'h0001;
    end else begin
      stab_cycles_q <= 13'h0000;
    end
  end

  a_stab_length: assert property (@(posedge clock_in) disable iff (reset_in)
    state_q == ST_STAB && state_d == ST_RUN
      |=> stab_cycles_q == (delay_long ? STAB_LONG_CYCLES : STAB_SHORT_CYCLES))
    else $error("stabilisation wait length differs from selected count");

  a_guard_clocks: assert property (@(posedge clock_in) disable iff (reset_in)
    state_q == ST_GUARD |-> !osc_enable_out && cpu_stall_out && !periph_clk_en_out)
    else $error("guard stop does not behave as full stop");

  a_pop_restore: assert property (@(posedge clock_in) disable iff (reset_in)
    cc_pop_in && !irq_take_in && !enter_sleep |=> cc_priority_out == $past(cc_pop_value_in))
    else $error("priority bits not restored on pop");

  c_tb_cycle: cover property (@(posedge clock_in) disable iff (reset_in)
    state_q == ST_TB_SLEEP ##1 state_q == ST_RUN);
  c_full_cycle: cover property (@(posedge clock_in) disable iff (reset_in)
    state_q == ST_STAB ##1 state_q == ST_RUN);
  c_guard: cover property (@(posedge clock_in) disable iff (reset_in)
    state_q == ST_GUARD);
  c_wd_reset: cover property (@(posedge clock_in) disable iff (reset_in)
    watchdog_reset_req_out);
endmodule : lpsc_stop_ctrl

// File: logic/lpsc_pkg.sv
package lpsc_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;

  // ==========================================================
  // Control register fields
  localparam int          CTRL_OSC_IRQ_BIT  = 0;
  localparam int          CTRL_LONG_DLY_BIT = 1;
  localparam int          CTRL_WD_STOP_BIT  = 2;
  localparam logic [2:0]  CTRL_RESET        = 3'h0;

  // ==========================================================
  // Status register fields
  localparam int          STAT_STATE_LSB = 0;
  localparam int          STAT_STALL_BIT = 5;
  localparam int          STAT_PRIO_LSB  = 6;

  // ==========================================================
  // Core interface constants
  localparam logic [7:0]  OPCODE_STOP     = 8'h8E;
  localparam logic [1:0]  PRIO_SLEEP      = 2'h2;
  localparam logic [1:0]  PRIO_RESET      = 2'h3;

  // ==========================================================
  // Stabilisation wait, in CPU cycles (one CPU cycle per clock)
  localparam int          CNT_W            = 13;
  localparam int          STAB_SHORT_TCPU  = 256;
  localparam int          STAB_LONG_TCPU   = 4096;
  localparam int          TCPU_PER_CLK     = 1;
  localparam logic [12:0] STAB_SHORT_CYCLES = 13'(STAB_SHORT_TCPU / TCPU_PER_CLK);
  localparam logic [12:0] STAB_LONG_CYCLES  = 13'(STAB_LONG_TCPU / TCPU_PER_CLK);

  // ==========================================================
  // Power states
  typedef enum logic [4:0] {
    ST_RUN      = 5'h01,
    ST_TB_SLEEP = 5'h02,
    ST_STOP     = 5'h04,
    ST_STAB     = 5'h08,
    ST_GUARD    = 5'h10
  } lpsc_state_e;
endpackage : lpsc_pkg

// File: logic/lpsc_stab_counter.sv
`timescale 1ns/100ps
module lpsc_stab_counter
  import lpsc_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic         clock_in,
  input  wire logic         reset_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] load_value_in,
  output logic              busy_out,
  output logic              expire_out
);
  logic [W-1:0] count_q;

  // Counts down on the restarted oscillator; reset starts a short wait
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      count_q <= W'(STAB_SHORT_CYCLES);
    end else if (load_in) begin
      count_q <= load_value_in;
    end else if (count_q != '0) begin
      count_q <= count_q - W'(1);
    end
  end

  assign busy_out   = (count_q != '0);
  assign expire_out = (count_q == W'(1)) && !load_in;
endmodule : lpsc_stab_counter

// File: dv/lpsc_core_model.sv
`timescale 1ns/100ps
// ==========================================================
// CPU core model: issues opcodes and interrupt entry/exit
module lpsc_core_model (
  input  wire logic clock_in,
  input  wire logic stall_in,
  output logic       instr_valid_out,
  output logic [7:0] opcode_out,
  output logic       irq_take_out,
  output logic [1:0] irq_level_out,
  output logic       cc_pop_out,
  output logic [1:0] cc_pop_value_out
);
  initial begin
    instr_valid_out = 1'b0;
    opcode_out = 8'h00;
    irq_take_out = 1'b0;
    irq_level_out = 2'h0;
    cc_pop_out = 1'b0;
    cc_pop_value_out = 2'h0;
  end
  // A stalled core issues no opcode (take_irq does not wait); wake sources are raised after stop
  task automatic exec_op(input logic [7:0] op);
    while (stall_in !== 1'b0) @(negedge clock_in);
    @(posedge clock_in);
    instr_valid_out <= 1'b1;
    opcode_out <= op;
    @(posedge clock_in);
    instr_valid_out <= 1'b0;
    opcode_out <= ~op;
  endtask : exec_op
  task automatic take_irq(input logic [1:0] lvl, input logic pop);
    @(posedge clock_in);
    irq_take_out <= ~pop;
    irq_level_out <= lvl;
    cc_pop_out <= pop;
    cc_pop_value_out <= lvl;
    @(posedge clock_in);
    irq_take_out <= 1'b0;
    cc_pop_out <= 1'b0;
    irq_level_out <= ~lvl;
    cc_pop_value_out <= ~lvl;
  endtask : take_irq
endmodule : lpsc_core_model

// File: dv/tb.sv
`timescale 1ns/100ps
module tb
  import lpsc_pkg::*;
;
  logic clock_in = 1'b0, reset_in = 1'b1;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic pready_out, pslverr_out, er, instr_valid_in, irq_take_in, cc_pop_in, cc_push_out;
  logic [7:0] opcode_in;
  logic [1:0] irq_level_in, cc_pop_value_in, cc_priority_out, cc_push_value_out;
  logic cpu_stall_out, time_base_irq_in = 1'b0, wake_irq_in = 1'b0, watchdog_active_in = 1'b0;
  logic watchdog_reset_req_out, osc_enable_out, time_base_clk_en_out, periph_clk_en_out, seen;
  int n_errors = 0, total_checks = 0;
  always #20 clock_in = ~clock_in;
  lpsc_stop_ctrl dut_u (.clock_in(clock_in), .reset_in(reset_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .instr_valid_in(instr_valid_in), .opcode_in(opcode_in), .irq_take_in(irq_take_in),
    .irq_level_in(irq_level_in), .cc_pop_in(cc_pop_in), .cc_pop_value_in(cc_pop_value_in),
    .cc_priority_out(cc_priority_out), .cc_push_out(cc_push_out),
    .cc_push_value_out(cc_push_value_out), .cpu_stall_out(cpu_stall_out),
    .time_base_irq_in(time_base_irq_in), .wake_irq_in(wake_irq_in),
    .watchdog_active_in(watchdog_active_in), .watchdog_reset_req_out(watchdog_reset_req_out),
    .osc_enable_out(osc_enable_out), .time_base_clk_en_out(time_base_clk_en_out),
    .periph_clk_en_out(periph_clk_en_out));
  lpsc_core_model core_u (.clock_in(clock_in), .stall_in(cpu_stall_out),
    .instr_valid_out(instr_valid_in), .opcode_out(opcode_in), .irq_take_out(irq_take_in),
    .irq_level_out(irq_level_in), .cc_pop_out(cc_pop_in), .cc_pop_value_out(cc_pop_value_in));
  // ==========================================================
  // Checks and bus cycles
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clock_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge clock_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    pwdata_in <= ~wd;
  endtask : apb
  task automatic count_stall(input int exp);
    int n;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
      @(negedge clock_in);
    end while (cpu_stall_out !== 1'b0 && n < 5000);
    chk(n, exp);
  endtask : count_stall
  task automatic pulse_reset();
    @(posedge clock_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
  endtask : pulse_reset
  task automatic stop_wake(input logic [31:0] ctrl, input int exp);
    apb(1'b1, CTRL_OFFSET, ctrl);
    core_u.exec_op(OPCODE_STOP);
    @(negedge clock_in);
    chk({cpu_stall_out, osc_enable_out, periph_clk_en_out, cc_priority_out}, 5'h12);
    @(posedge clock_in);
    wake_irq_in <= 1'b1;
    count_stall(exp);
    @(posedge clock_in);
    wake_irq_in <= 1'b0;
  endtask : stop_wake
  initial begin
    repeat (30000) @(posedge clock_in);
    n_errors++;
    test_done();
  end
  // ==========================================================
  // Test sequence
  initial begin
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    count_stall(256);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk(rd, 32'hC1);
    apb(1'b1, CTRL_OFFSET, 32'hFFFF_FFFF);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk(rd, 32'h7);
    apb(1'b0, 12'h008, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    $display("test registers done");
    core_u.take_irq(2'h1, 1'b0);
    @(negedge clock_in);
    chk({cc_push_out, cc_push_value_out, cc_priority_out}, 5'h1D);
    core_u.take_irq(2'h3, 1'b1);
    @(negedge clock_in);
    chk(cc_priority_out, 2'h3);
    core_u.exec_op(8'h8F);
    @(negedge clock_in);
    chk({cpu_stall_out, osc_enable_out}, 2'h1);
    $display("test irq done");
    stop_wake(32'h0, STAB_SHORT_CYCLES + 1);
    stop_wake(32'h2, STAB_LONG_CYCLES + 1);
    $display("test full stop done");
    watchdog_active_in <= 1'b1;
    apb(1'b1, CTRL_OFFSET, 32'h4);
    core_u.exec_op(OPCODE_STOP);
    seen = 1'b0;
    repeat (3) begin
      @(negedge clock_in);
      seen |= watchdog_reset_req_out;
    end
    chk({seen, cpu_stall_out}, 2'h2);
    apb(1'b1, CTRL_OFFSET, 32'h5);
    core_u.exec_op(OPCODE_STOP);
    seen = 1'b0;
    wake_irq_in <= 1'b1;
    repeat (4) begin
      @(negedge clock_in);
      seen |= watchdog_reset_req_out;
    end
    chk(seen, 1'b0);
    chk({cpu_stall_out, osc_enable_out, time_base_clk_en_out, periph_clk_en_out}, 4'hE);
    chk(cc_priority_out, PRIO_SLEEP);
    @(posedge clock_in);
    wake_irq_in <= 1'b0;
    time_base_irq_in <= 1'b1;
    @(posedge clock_in);
    time_base_irq_in <= 1'b0;
    @(negedge clock_in);
    chk(cpu_stall_out, 1'b0);
    apb(1'b1, CTRL_OFFSET, 32'h0);
    repeat (2) @(negedge clock_in);
    chk({cpu_stall_out, osc_enable_out}, 2'h2);
    // Window opened at the wake edge; the write and the two waits used 4 of its cycles
    count_stall(STAB_SHORT_CYCLES - 4);
    $display("test time base sleep done");
    apb(1'b1, CTRL_OFFSET, 32'h1);
    core_u.exec_op(OPCODE_STOP);
    pulse_reset();
    count_stall(STAB_SHORT_CYCLES);
    $display("test reset exit done");
    test_done();
  end
endmodule : tb
